// ===== hdl/rai_pkg.sv
// constants and types for the relay assignment and inhibit block
// assumes one system clock; register port carries 16-bit register addresses
package rai_pkg;

    // ----------------------------------------------------------------
    // register addresses (32-bit bitmaps)
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_INS_MAP  = 16'hBE4;
    localparam logic [15:0] ADDR_PREV_MAP = 16'hBE6;

    // ----------------------------------------------------------------
    // bitmap field positions
    // ----------------------------------------------------------------
    localparam int BIT_PRE_ALARM  = 0;
    localparam int BIT_INS_ALARM  = 4;
    localparam int BIT_INJ_INHIB  = 8;
    localparam int BIT_SYS_ERROR  = 16;
    localparam int BIT_PROD_ERROR = 24;

    localparam logic [31:0] MAP_DEFINED = 32'h0101_0111;
    localparam logic [31:0] INS_WR_MASK = 32'h0101_0101;
    localparam logic [31:0] PREV_WR_MASK = 32'h0101_0110;

    // ----------------------------------------------------------------
    // factory reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] INS_MAP_RESET  = 32'h0101_0010;
    localparam logic [31:0] PREV_MAP_RESET = 32'h0101_0000;

    // ----------------------------------------------------------------
    // modes and carriers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PREV_STANDARD,
        PREV_FAILSAFE,
        PREV_MIRROR
    } rai_prev_mode_e;

    typedef enum logic [1:0] {
        INH_NO,
        INH_NC,
        INH_OFF
    } rai_inh_mode_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } rai_req_s;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic [31:0] rdata;
    } rai_resp_s;

endpackage

// ===== hdl/rai_relay_assign.sv
// relay assignment bitmaps, relay drive and injection inhibit decision
// assumes register requests and settings come from logic on sys_clk;
// only the inhibit contact arrives from a pin
//
// How it works
// RQ1 - two 32-bit bitmaps: main relay at 0xBE4, preventive relay at 0xBE6
// RQ2 - bit 0 is preventive alarm; read-only in the preventive bitmap
// RQ3 - bit 4 is insulation alarm; read-only in the main bitmap
// RQ4 - bits 8, 16, 24: inhibit, system error, product error; rest reserved
// RQ5 - failed self-test counts as product error
// RQ6 - factory reset main bitmap: insulation alarm, system and product error
// RQ7 - factory reset preventive bitmap: system and product error only
// RQ8 - threshold not off forces preventive alarm bit in preventive bitmap
// RQ9 - mirror mode clears preventive bitmap, follows main relay, refuses writes
// RQ10 - acknowledge off clears inhibit bit in both bitmaps, refuses it
// RQ11 - acknowledge on sets inhibit bit in main bitmap
// RQ12 - normally-open input: inject while open, stop while closed
// RQ13 - normally-closed input: inject while closed, stop while open
// RQ14 - input off: pin ignored, exclusion only by protocol command
// RQ15 - outside logic lets at most one device inject per system
// RQ16 - two feeders: outside logic inhibits second device when both closed
// RQ17 - assignments changed only by register port, shown read-only on display
// RQ18 - mirror follows main relay only while device operates correctly
// RQ19 - relay asserted when any assigned state is active
// RQ20 - reserved bits read zero and ignore writes
`timescale 1ns/10ps
`default_nettype none

module rai_relay_assign (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire rai_pkg::rai_req_s       regReq,
    output var  rai_pkg::rai_resp_s      regResp,
    input  wire logic                    factoryReset,
    input  wire logic                    prevThresholdOn,
    input  wire rai_pkg::rai_prev_mode_e preventive_relay_mode,
    input  wire logic                    inhibitAck,
    input  wire rai_pkg::rai_inh_mode_e  inhibitInputMode,
    input  wire logic                    inhibitContactClosed,
    input  wire logic                    busInhibitCmd,
    input  wire logic                    preAlarmState,
    input  wire logic                    insAlarmState,
    input  wire logic                    systemErrorState,
    input  wire logic                    productErrorState,
    input  wire logic                    selfTestFailed,
    input  wire logic                    deviceOperating,
    output logic                         main_alarm_relay,
    output logic                         preventive_alarm_relay,
    output logic                         injectEnable,
    output logic [31:0]                  displayInsMap,
    output logic [31:0]                  displayPrevMap
);
    import rai_pkg::*;

    // ----------------------------------------------------------------
    // inhibit contact synchroniser
    // ----------------------------------------------------------------
    logic contactMeta;
    logic contactSync;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            contactMeta <= 1'b0;
            contactSync <= 1'b0;
        end else begin
            contactMeta <= inhibitContactClosed;
            contactSync <= contactMeta;
        end
    end

    // ----------------------------------------------------------------
    // injection inhibit decision
    // ----------------------------------------------------------------
    logic inhibited;
    logic next_inhibited;

    always_comb begin
        case (inhibitInputMode)
            INH_NO:  next_inhibited = contactSync;     // RQ12
            INH_NC:  next_inhibited = !contactSync;    // RQ13
            default: next_inhibited = busInhibitCmd;   // RQ14
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            inhibited    <= 1'b0;
            injectEnable <= 1'b1;
        end else begin
            inhibited    <= next_inhibited;
            // own flop so the injection output never glitches
            injectEnable <= !next_inhibited;
        end
    end

    // ----------------------------------------------------------------
    // bitmaps
    // ----------------------------------------------------------------
    logic [31:0] insMap;
    logic [31:0] prevMap;
    logic [31:0] next_insMap;
    logic [31:0] next_prevMap;
    logic        wrIns;
    logic        wrPrev;
    logic        isMirror;

    // merge a write into a map, only through the writable mask
    function automatic logic [31:0] merge(input logic [31:0] cur,
                                          input logic [31:0] wd,
                                          input logic [31:0] mask);
        merge = (cur & ~mask) | (wd & mask);
    endfunction

    assign isMirror = (preventive_relay_mode == PREV_MIRROR);

    always_comb begin
        wrIns  = 1'b0;
        wrPrev = 1'b0;
        if (regReq.write && regReq.addr == ADDR_INS_MAP) begin
            wrIns = 1'b1;
        end else if (regReq.write && regReq.addr == ADDR_PREV_MAP) begin
            wrPrev = 1'b1;
        end
    end

    always_comb begin
        next_insMap  = insMap;
        next_prevMap = prevMap;
        if (factoryReset) begin
            next_insMap  = INS_MAP_RESET;    // RQ6
            next_prevMap = PREV_MAP_RESET;   // RQ7
        end else begin
            if (wrIns) begin
                next_insMap = merge(insMap, regReq.wdata, INS_WR_MASK);   // RQ17
            end
            if (wrPrev && !isMirror) begin
                next_prevMap = merge(prevMap, regReq.wdata, PREV_WR_MASK);
            end
        end
        // forcing is applied last so it overrides any write in the same cycle
        next_insMap[BIT_INS_ALARM]   = 1'b1;                  // RQ3
        next_prevMap[BIT_PRE_ALARM]  = prevThresholdOn;       // RQ2 RQ8
        if (!inhibitAck) begin
            next_insMap[BIT_INJ_INHIB]  = 1'b0;               // RQ10
            next_prevMap[BIT_INJ_INHIB] = 1'b0;               // RQ10
        end else begin
            next_insMap[BIT_INJ_INHIB]  = 1'b1;               // RQ11
        end
        if (isMirror) begin
            next_prevMap = 32'h0000_0000;                     // RQ9
        end
        next_insMap  = next_insMap & MAP_DEFINED;             // RQ4 RQ20
        next_prevMap = next_prevMap & MAP_DEFINED;            // RQ20
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            insMap  <= INS_MAP_RESET;    // RQ1 RQ6
            prevMap <= PREV_MAP_RESET;   // RQ1 RQ7
        end else begin
            insMap  <= next_insMap;
            prevMap <= next_prevMap;
        end
    end

    // ----------------------------------------------------------------
    // register read answer
    // ----------------------------------------------------------------
    rai_resp_s next_regResp;

    always_comb begin
        next_regResp = '0;
        if (regReq.read || regReq.write) begin
            next_regResp.valid = 1'b1;
            if (regReq.addr == ADDR_INS_MAP) begin
                next_regResp.rdata = insMap;
            end else if (regReq.addr == ADDR_PREV_MAP) begin
                next_regResp.rdata = prevMap;
            end else begin
                next_regResp.error = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regResp <= '0;
        end else begin
            regResp <= next_regResp;
        end
    end

    // ----------------------------------------------------------------
    // relay drive
    // ----------------------------------------------------------------
    logic [31:0] stateVec;
    logic        mainHit;
    logic        prevHit;
    logic        next_mainRelay;
    logic        next_prevRelay;

    always_comb begin
        stateVec                 = 32'h0000_0000;
        stateVec[BIT_PRE_ALARM]  = preAlarmState;
        stateVec[BIT_INS_ALARM]  = insAlarmState;
        stateVec[BIT_INJ_INHIB]  = inhibited;
        stateVec[BIT_SYS_ERROR]  = systemErrorState;
        stateVec[BIT_PROD_ERROR] = productErrorState || selfTestFailed;   // RQ5
    end

    assign mainHit = |(insMap & stateVec);    // RQ19
    assign prevHit = |(prevMap & stateVec);   // RQ19

    always_comb begin
        next_mainRelay = mainHit;
        if (isMirror) begin
            // an inoperative device drops the copy so the pair reveals it
            next_prevRelay = mainHit && deviceOperating;   // RQ9 RQ18
        end else begin
            next_prevRelay = prevHit;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            main_alarm_relay       <= 1'b0;
            preventive_alarm_relay <= 1'b0;
        end else begin
            main_alarm_relay       <= next_mainRelay;
            preventive_alarm_relay <= next_prevRelay;
        end
    end

    assign displayInsMap  = insMap;    // RQ17
    assign displayPrevMap = prevMap;   // RQ17

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_closedNo;
        (inhibitInputMode == INH_NO && inhibitContactClosed) [*4];
    endsequence

    sequence s_openNc;
        (inhibitInputMode == INH_NC && !inhibitContactClosed) [*4];
    endsequence

    sequence s_insWrite;
        wrIns && !factoryReset;
    endsequence

    a_ins_ro_bit: assert property (insMap[BIT_INS_ALARM]) // RQ3
        else $error("insulation alarm bit not held in main bitmap");

    a_prev_ro_bit: assert property (1'b1 |=> prevMap[BIT_PRE_ALARM] == // RQ2
        $past(prevThresholdOn && !isMirror))
        else $error("preventive alarm bit does not follow threshold");

    a_reserved_zero: assert property (((insMap | prevMap) & ~MAP_DEFINED) == 32'h0) // RQ20
        else $error("reserved bitmap bit set");

    a_mirror_clear: assert property (isMirror |=> prevMap == 32'h0) // RQ9
        else $error("preventive bitmap not cleared in mirror mode");

    a_ack_off: assert property (!inhibitAck |=> !insMap[BIT_INJ_INHIB] && !prevMap[BIT_INJ_INHIB]) // RQ10
        else $error("inhibit bit kept with acknowledge off");

    a_ack_on: assert property (inhibitAck |=> insMap[BIT_INJ_INHIB]) // RQ11
        else $error("inhibit bit missing with acknowledge on");

    a_relay_or: assert property (1'b1 |=> main_alarm_relay == $past(mainHit)) // RQ19
        else $error("main relay differs from assigned states");

    a_mirror_follow: assert property (isMirror && deviceOperating |=> // RQ18
        preventive_alarm_relay == main_alarm_relay)
        else $error("preventive relay does not mirror main relay");

    a_mirror_drop: assert property (isMirror && !deviceOperating |=> !preventive_alarm_relay) // RQ18
        else $error("mirror kept while device inoperative");

    a_pin_no: assert property (s_closedNo |=> !injectEnable) // RQ12
        else $error("injection with normally-open contact closed");

    a_pin_nc: assert property (s_openNc |=> !injectEnable) // RQ13
        else $error("injection with normally-closed contact open");

    a_off_ignore: assert property (inhibitInputMode == INH_OFF |=> // RQ14
        injectEnable == !$past(busInhibitCmd))
        else $error("inhibit not taken from command in off mode");

    a_ins_write: assert property (s_insWrite |=> // RQ17
        insMap[BIT_SYS_ERROR] == $past(regReq.wdata[BIT_SYS_ERROR]))
        else $error("main bitmap write not stored");

    a_bus_answer: assert property (regReq.read || regReq.write |=> regResp.valid) // RQ1
        else $error("register request without answer");

endmodule // rai_relay_assign

`default_nettype wire

// ===== sim/rai_feeder_logic.sv
// two-feeder exclusion model driving the inhibit contact of device 2
// assumes the bench moves breakers between clock edges
`timescale 1ns/10ps
`default_nettype none

module rai_feeder_logic (
    input  wire logic first_feeder_breaker,
    input  wire logic second_feeder_breaker,
    input  wire logic contactNc,
    output logic      contactClosed
);
    // device 1 always injects; device 2 yields on a closed path
    wire logic inhibitDemand = first_feeder_breaker & second_feeder_breaker;
    assign contactClosed = contactNc ? !inhibitDemand : inhibitDemand;
endmodule // rai_feeder_logic

`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for rai_relay_assign
// assumes sys_clk at 25 MHz and the feeder model rai_feeder_logic
`timescale 1ns/10ps
`default_nettype none

module tb;
    import rai_pkg::*;
    typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] e;} rai_wrow_s;
    logic           sys_clk = 0;
    logic           sys_rst = 1;
    rai_req_s       regReq = '0;
    rai_resp_s      regResp, rsp;
    logic           factoryReset = 0, thrOn = 1, ack = 0, cmd = 0, pinClosed;
    rai_prev_mode_e prevMode = PREV_STANDARD;
    rai_inh_mode_e  inhMode = INH_NO;
    logic [4:0]     st = '0; // pre, ins, sys, prod, self-test
    logic           devOk = 1, fb1 = 0, fb2 = 0, mainRly, prevRly, inject;
    logic [31:0]    insMap, prevMap;
    int             fails = 0, num_checks = 0, cyc = 0;
    // write then read back: address, data written, value read
    rai_wrow_s wr [6] = '{'{16'hBE4, 32'hFFFFFFFF, 32'h01010011}, '{16'hBE4, 32'h0, 32'h00000010},
        '{16'hBE6, 32'hFFFFFFFF, 32'h01010011}, '{16'hBE6, 32'h0, 32'h00000001},
        '{16'hBE4, 32'h01000001, 32'h01000011}, '{16'hBE6, 32'h00000010, 32'h00000011}};
    // states in [6:2], expected main relay [1], preventive relay [0]
    logic [6:0] rly [6] = '{7'h00, 7'h43, 7'h23, 7'h10, 7'h0A, 7'h06};

    rai_relay_assign dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .regReq(regReq), .regResp(regResp),
        .factoryReset(factoryReset), .prevThresholdOn(thrOn), .preventive_relay_mode(prevMode),
        .inhibitAck(ack), .inhibitInputMode(inhMode), .inhibitContactClosed(pinClosed),
        .busInhibitCmd(cmd), .preAlarmState(st[4]), .insAlarmState(st[3]), .systemErrorState(st[2]),
        .productErrorState(st[1]), .selfTestFailed(st[0]), .deviceOperating(devOk),
        .main_alarm_relay(mainRly), .preventive_alarm_relay(prevRly), .injectEnable(inject),
        .displayInsMap(insMap), .displayPrevMap(prevMap));
    rai_feeder_logic fdr_u (.first_feeder_breaker(fb1), .second_feeder_breaker(fb2),
        .contactNc(inhMode == INH_NC), .contactClosed(pinClosed));

    always #20 sys_clk = ~sys_clk;

    // a run needs about 120 cycles; 3000 means a hang
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk) #1;
        regReq = '{read: !w, write: w, addr: a, wdata: d};
        tick(1);
        regReq = '0;
        rsp = regResp;
        chk(rsp.valid, 1);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(1);
        chk(insMap, 32'h01010010);
        chk(prevMap, 32'h01010000);
        chk(inject, 1);
        tick(1);
        sys_rst = 0;
        tick(2);
        chk(prevMap, 32'h01010001);
        $display("done: reset");
        for (int i = 0; i < 6; i++) begin
            acc(1, wr[i].a, wr[i].d);
            acc(0, wr[i].a, 32'h0);
            chk(rsp.error, 0);
            chk(rsp.rdata, wr[i].e);
        end
        for (int i = 0; i < 6; i++) begin
            st = rly[i][6:2];
            tick(2);
            chk(mainRly, rly[i][1]);
            chk(prevRly, rly[i][0]);
        end
        st = '0;
        $display("done: table");
        acc(0, 16'hBE5, 32'h0);
        chk(rsp.error, 1);
        chk(rsp.rdata, 0);
        acc(1, 16'hBE7, 32'hFFFFFFFF);
        chk(rsp.error, 1);
        ack = 1;
        tick(2);
        chk(insMap, 32'h01000111);
        acc(1, 16'hBE6, 32'h00000110);
        chk(prevMap, 32'h00000111);
        cmd = 1;
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 4; k++) begin
                inhMode = m ? INH_NC : INH_NO;
                {fb1, fb2} = k[1:0];
                tick(6);
                chk(inject, !(fb1 & fb2));
                chk(mainRly, fb1 & fb2);
                chk(prevRly, fb1 & fb2);
            end
        end
        cmd = 0;
        inhMode = INH_OFF;
        tick(3);
        chk(inject, 1);
        cmd = 1;
        tick(2);
        chk(inject, 0);
        {cmd, fb1, fb2} = '0;
        inhMode = INH_NO;
        ack = 0;
        tick(2);
        chk(insMap, 32'h01000011);
        chk(prevMap, 32'h00000011);
        $display("done: inhibit");
        prevMode = PREV_MIRROR;
        tick(2);
        chk(prevMap, 0);
        acc(1, 16'hBE6, 32'h01010110);
        tick(1);
        chk(prevMap, 0);
        st = 5'h08;
        tick(2);
        chk(mainRly, 1);
        chk(prevRly, 1);
        devOk = 0;
        tick(2);
        chk(prevRly, 0);
        {devOk, st} = 6'h20;
        prevMode = PREV_STANDARD;
        factoryReset = 1;
        tick(1);
        factoryReset = 0;
        tick(2);
        chk(insMap, 32'h01010010);
        chk(prevMap, 32'h01010001);
        $display("done: mirror and factory reset");
        thrOn = 0;
        prevMode = PREV_FAILSAFE;
        acc(1, 16'hBE6, 32'h01000010);
        chk(prevMap, 32'h01000010);
        st = 5'h08;
        tick(2);
        chk(prevRly, 1);
        sys_rst = 1;
        tick(1);
        chk(mainRly, 0);
        chk(prevMap, 32'h01010000);
        sys_rst = 0;
        tick(2);
        chk(mainRly, 1);
        chk(prevRly, 0);
        chk(prevMap, 32'h01010000);
        $display("done: failsafe and mid-run reset");
        give_verdict();
    end
endmodule // tb

`default_nettype wire
